/* File: src/dft_params.svh */
// constants for the frequency translation front end
`ifndef DFT_PARAMS_SVH
`define DFT_PARAMS_SVH

// register addresses
`define DFT_ADDR_W          12
`define DFT_ADDR_SYNC       12'h300
`define DFT_ADDR_CH0        12'h310
`define DFT_ADDR_CH1        12'h330
`define DFT_ADDR_CH2        12'h350
`define DFT_ADDR_CH3        12'h370
`define DFT_REG_RESET       8'h00

// field positions
`define DFT_DEC_LSB         0
`define DFT_DEC_MSB         1
`define DFT_MODE_LSB        4
`define DFT_MODE_MSB        5
`define DFT_CPLX_BIT        7
`define DFT_SYNCEN_LSB      0
`define DFT_SYNCEN_MSB      1
`define DFT_SOFTRST_BIT     4

// oscillator and mixer
`define DFT_OSC_W           12
`define DFT_QUAD_STEP       2'h1
`define DFT_TEST_LEVEL      16'sh7FDE
`define DFT_CPLX_SCALE      16'sh59FF
`define DFT_SCALE_SHIFT     15
`define DFT_REAL_SHIFT      16
`define DFT_HALF_TURN       11'h400
`define DFT_INTERP_SHIFT    6

`endif

/* File: src/dft_pkg.sv */
// types shared by the frequency translation front end
`default_nettype none
package dft_pkg;

   typedef enum logic [1:0] {
      DFT_MODE_VARIABLE = 2'b00,
      DFT_MODE_ZERO_IF  = 2'b01,
      DFT_MODE_QUARTER  = 2'b10,
      DFT_MODE_TEST     = 2'b11
   } dft_if_mode_t;

   typedef struct packed {
      logic signed [15:0] i;
      logic signed [15:0] q;
   } dft_sample_t;

   typedef struct packed {
      logic         complexIn;
      logic         spare;
      dft_if_mode_t ifMode;
      logic [1:0]   spare2;
      logic [1:0]   decCode;
   } dft_chan_ctrl_t;

   // halfband_stage_1 .. halfband_stage_4 enables, bit 0 is stage 1
   typedef logic [3:0] dft_stage_en_t;

endpackage : dft_pkg
`default_nettype wire

/* File: src/dft_fifo.sv */
// sample fifo with valid/ready on both sides
`default_nettype none
module dft_fifo #(
   parameter int W     = 32,
   parameter int DEPTH = 16
) (
   input  wire logic         mclk,
   input  wire logic         rst_b,
   input  wire logic         inValid,
   output logic              inReady,
   input  wire logic [W-1:0] inData,
   output logic              outValid,
   input  wire logic         outReady,
   output logic [W-1:0]      outData
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr;
   logic [AW-1:0] rdPtr;
   logic [AW:0]   count;
   logic          doWrite;
   logic          doRead;

   assign inReady  = (count != (AW+1)'(DEPTH));
   assign outValid = (count != '0);
   assign outData  = mem[rdPtr];
   assign doWrite  = inValid && inReady;
   assign doRead   = outValid && outReady;

   always_ff @(posedge mclk) begin
      if (doWrite) begin
         mem[wrPtr] <= inData;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         if (doWrite) begin
            wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + AW'(1);
         end
         if (doRead) begin
            rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + AW'(1);
         end
         count <= count + (AW+1)'(doWrite) - (AW+1)'(doRead);
      end
   end
endmodule : dft_fifo
`default_nettype wire

/* File: src/dft_osc_mixer.sv */
// per-channel tuning oscillator and quadrature mixer
`include "dft_params.svh"
`default_nettype none
module dft_osc_mixer (
   input  wire logic                   mclk,
   input  wire logic                   rst_b,
   input  wire logic                   advance,
   input  wire logic                   restart,
   input  wire dft_pkg::dft_if_mode_t  ifMode,
   input  wire logic                   complexIn,
   input  wire logic [`DFT_OSC_W-1:0]  tuneWord,
   input  wire logic [`DFT_OSC_W-1:0]  phaseWord,
   input  wire dft_pkg::dft_sample_t   sampleIn,
   output dft_pkg::dft_sample_t        mixOut
);
   logic [`DFT_OSC_W-1:0] phaseAcc;
   logic [1:0]            quarterStep;

   // quarter-wave table, peak already 0.05 dB below full scale
   function automatic logic [15:0] dftSinTab(input logic [4:0] k);
      unique case (k)
         5'h00:   return 16'h0000;
         5'h01:   return 16'h0C7A;
         5'h02:   return 16'h18D4;
         5'h03:   return 16'h24F2;
         5'h04:   return 16'h30B4;
         5'h05:   return 16'h3BFE;
         5'h06:   return 16'h46B5;
         5'h07:   return 16'h50BD;
         5'h08:   return 16'h59FD;
         5'h09:   return 16'h6260;
         5'h0A:   return 16'h69D2;
         5'h0B:   return 16'h703C;
         5'h0C:   return 16'h7594;
         5'h0D:   return 16'h79C8;
         5'h0E:   return 16'h7CD3;
         5'h0F:   return 16'h7EA8;
         default: return 16'h7F44;
      endcase
   endfunction : dftSinTab

   function automatic logic signed [15:0] dftSin(input logic [`DFT_OSC_W-1:0] p);
      logic [10:0] v;
      logic [15:0] a;
      logic [15:0] b;
      logic [21:0] d;
      logic [15:0] m;
      v = p[10] ? (`DFT_HALF_TURN - {1'b0, p[9:0]}) : {1'b0, p[9:0]};
      a = dftSinTab(v[10:6]);
      b = dftSinTab(v[10:6] + 5'h01);
      d = {6'h00, b - a} * {16'h0000, v[5:0]};
      m = a + d[21:`DFT_INTERP_SHIFT];
      return p[11] ? -$signed(m) : $signed(m);
   endfunction : dftSin

   // complex results scaled down 3.06 dB so they cannot exceed full scale
   function automatic logic signed [15:0] dftCplxScale(input logic signed [33:0] s);
      logic signed [18:0] t;
      logic signed [34:0] u;
      t = 19'(s >>> `DFT_SCALE_SHIFT);
      u = 35'(t) * 35'(`DFT_CPLX_SCALE);
      return 16'(u >>> `DFT_SCALE_SHIFT);
   endfunction : dftCplxScale

   // phase accumulator: load offset on sync, step by tuning word per sample
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         phaseAcc    <= '0;
         quarterStep <= '0;
      end else if (restart) begin
         phaseAcc    <= phaseWord;
         quarterStep <= '0;
      end else if (advance) begin
         if (ifMode != dft_pkg::DFT_MODE_ZERO_IF) begin
            phaseAcc <= phaseAcc + tuneWord;
         end
         quarterStep <= quarterStep + `DFT_QUAD_STEP;
      end
   end

   always_comb begin
      logic signed [15:0] xi;
      logic signed [15:0] xq;
      logic signed [15:0] c;
      logic signed [15:0] s;
      logic signed [15:0] ri;
      logic signed [15:0] rq;
      logic signed [31:0] pIc;
      logic signed [31:0] pIs;
      logic signed [31:0] pQc;
      logic signed [31:0] pQs;
      ri  = '0;
      rq  = '0;
      xi  = sampleIn.i;
      xq  = complexIn ? sampleIn.q : 16'sh0000;
      if (ifMode == dft_pkg::DFT_MODE_TEST) begin
         xi = `DFT_TEST_LEVEL;
         xq = complexIn ? `DFT_TEST_LEVEL : 16'sh0000;
      end
      c   = dftSin(phaseAcc + 12'h400);
      s   = dftSin(phaseAcc);
      pIc = xi * c;
      pIs = xi * s;
      pQc = xq * c;
      pQs = xq * s;
      // fixed rotation by -fs/4: only swaps and negations
      unique case (quarterStep)
         2'h0:    begin ri = xi;  rq = xq;  end
         2'h1:    begin ri = xq;  rq = -xi; end
         2'h2:    begin ri = -xi; rq = -xq; end
         default: begin ri = -xq; rq = xi;  end
      endcase
      unique case (ifMode)
         dft_pkg::DFT_MODE_ZERO_IF: begin
            mixOut.i = sampleIn.i;
            mixOut.q = complexIn ? sampleIn.q : 16'sh0000;
         end
         dft_pkg::DFT_MODE_QUARTER: begin
            if (complexIn) begin
               mixOut.i = dftCplxScale(34'(ri) <<< `DFT_SCALE_SHIFT);
               mixOut.q = dftCplxScale(34'(rq) <<< `DFT_SCALE_SHIFT);
            end else begin
               mixOut.i = ri >>> 1;
               mixOut.q = rq >>> 1;
            end
         end
         default: begin
            if (complexIn) begin
               mixOut.i = dftCplxScale(34'(pIc) + 34'(pQs));
               mixOut.q = dftCplxScale(34'(pQc) - 34'(pIs));
            end else begin
               mixOut.i = 16'(pIc >>> `DFT_REAL_SHIFT);
               mixOut.q = 16'(-(pIs >>> `DFT_REAL_SHIFT));
            end
         end
      endcase
   end
endmodule : dft_osc_mixer
`default_nettype wire

/* File: src/dft_frequency_translation.sv */
// four-channel frequency translation front end with stage selection
//
// What this block does
// - per-channel control register, mode field bits 5:4
// - variable mode runs oscillator and mixers
// - zero IF bypasses mixers, oscillator disabled
// - quarter-rate mode uses fs/4 downmix
// - test mode forces 0.999 full scale input
// - real input total loss 6.07 dB, 6.02 dB in quarter-rate mode
// - complex mixing loses 3.06 plus 0.05 dB, 3.06 dB alone in quarter-rate mode
// - tuning word is 12-bit two's complement
// - each oscillator has 12-bit phase offset
// - accumulator loads offset, steps by tuning word
// - soft reset bit 4 high-low resets accumulators
// - enabled sync pin event resets all accumulators
// - real uses two multipliers, complex four
// - control bit 7 selects real or complex
// - four halfband stages, first never bypassed
// - bits 1:0 set channel decimation ratio
// - fourth stage only complex 16, real 8
// - third stage only complex 8/16, real 4/8
`include "dft_params.svh"
`default_nettype none
module dft_frequency_translation #(
   parameter int         CHANNELS   = 4,
   parameter int         FIFO_DEPTH = 16,
   // optional stages (halfband_stage_2..4) added for each decimation code
   parameter logic [7:0] DEC_MAP    = 8'hE4
) (
   input  wire logic                                  mclk,
   input  wire logic                                  rst_b,
   input  wire logic                                  adcValid,
   output logic                                       adcReady,
   input  wire dft_pkg::dft_sample_t                  adcSample,
   input  wire logic [CHANNELS-1:0][`DFT_OSC_W-1:0]   tuneWord,
   input  wire logic [CHANNELS-1:0][`DFT_OSC_W-1:0]   phaseWord,
   input  wire logic                                  syncPin,
   input  wire logic                                  syncPinEnable,
   input  wire logic                                  regWrEn,
   input  wire logic [`DFT_ADDR_W-1:0]                regAddr,
   input  wire logic [7:0]                            regWrData,
   output logic [7:0]                                 regRdData,
   output logic                                       chanValid,
   input  wire logic                                  chanReady,
   output dft_pkg::dft_sample_t [CHANNELS-1:0]        chanData,
   output dft_pkg::dft_stage_en_t [CHANNELS-1:0]      stageEnable
);
   localparam int SW = $bits(dft_pkg::dft_sample_t);

   dft_pkg::dft_chan_ctrl_t [CHANNELS-1:0] chanCtrl;
   logic [7:0]                             syncCtrl;
   logic                                   syncPinMeta;
   logic                                   syncPinSafe;
   logic                                   syncPinLast;
   logic                                   softResetLast;
   logic                                   restart;
   logic                                   adcTake;
   logic                                   fifoValid;
   logic                                   fifoReady;
   dft_pkg::dft_sample_t                   fifoData;
   logic                                   advance;
   dft_pkg::dft_sample_t [CHANNELS-1:0]    mixOut;

   // channel index for an address, CHANNELS when not a channel register
   function automatic int dftChanOf(input logic [`DFT_ADDR_W-1:0] a);
      unique case (a)
         `DFT_ADDR_CH0: return 0;
         `DFT_ADDR_CH1: return 1;
         `DFT_ADDR_CH2: return 2;
         `DFT_ADDR_CH3: return 3;
         default:       return CHANNELS;
      endcase
   endfunction : dftChanOf

   // stage enables from decimation code; stage count grows with the ratio
   function automatic dft_pkg::dft_stage_en_t dftStages(input logic [1:0] code);
      logic [1:0] extra;
      extra = DEC_MAP[2*code +: 2];
      return {extra == 2'h3,
              extra >= 2'h2,
              extra >= 2'h1,
              1'b1};
   endfunction : dftStages

   // register writes
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         chanCtrl <= {CHANNELS{`DFT_REG_RESET}};
         syncCtrl <= `DFT_REG_RESET;
      end else if (regWrEn) begin
         if (regAddr == `DFT_ADDR_SYNC) begin
            syncCtrl <= regWrData;
         end
         for (int c = 0; c < CHANNELS; c++) begin
            if (dftChanOf(regAddr) == c) begin
               chanCtrl[c] <= regWrData;
            end
         end
      end
   end

   // register reads, unmapped addresses return zero
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         regRdData <= '0;
      end else if (regAddr == `DFT_ADDR_SYNC) begin
         regRdData <= syncCtrl;
      end else if (dftChanOf(regAddr) < CHANNELS) begin
         regRdData <= chanCtrl[2'(dftChanOf(regAddr))];
      end else begin
         regRdData <= '0;
      end
   end

   // sync pin comes from outside the clock domain
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         syncPinMeta <= 1'b0;
         syncPinSafe <= 1'b0;
         syncPinLast <= 1'b0;
      end else begin
         syncPinMeta <= syncPin;
         syncPinSafe <= syncPinMeta;
         syncPinLast <= syncPinSafe;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         softResetLast <= 1'b0;
      end else begin
         softResetLast <= syncCtrl[`DFT_SOFTRST_BIT];
      end
   end

   // accumulators restart on soft reset release or an enabled pin edge
   assign restart = (softResetLast && !syncCtrl[`DFT_SOFTRST_BIT]) ||
                    (syncPinEnable && (syncCtrl[`DFT_SYNCEN_MSB:`DFT_SYNCEN_LSB] != 2'b00) &&
                     syncPinSafe && !syncPinLast);

   // fifo writes only beats the registered ready accepted, else a held beat lands twice
   assign adcTake = adcValid && adcReady;

   dft_fifo #(
      .W     (SW),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .mclk     (mclk),
      .rst_b    (rst_b),
      .inValid  (adcTake),
      .inReady  (fifoReady),
      .inData   (adcSample),
      .outValid (fifoValid),
      .outReady (advance),
      .outData  (fifoData)
   );

   // adcReady is registered; dropping it for the cycle after each accept covers the cycle it lags
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         adcReady <= 1'b0;
      end else begin
         adcReady <= fifoReady && !(adcValid && adcReady);
      end
   end

   // a sample is consumed only when the output register can take it
   assign advance = fifoValid && (!chanValid || chanReady);

   for (genvar g = 0; g < CHANNELS; g++) begin : gChan
      dft_osc_mixer u_mix (
         .mclk      (mclk),
         .rst_b     (rst_b),
         .advance   (advance),
         .restart   (restart),
         .ifMode    (chanCtrl[g].ifMode),
         .complexIn (chanCtrl[g].complexIn),
         .tuneWord  (tuneWord[g]),
         .phaseWord (phaseWord[g]),
         .sampleIn  (fifoData),
         .mixOut    (mixOut[g])
      );
   end

   // output stage to the decimation filters
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         chanValid <= 1'b0;
         chanData  <= '0;
      end else if (advance) begin
         chanValid <= 1'b1;
         chanData  <= mixOut;
      end else if (chanReady) begin
         chanValid <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         stageEnable <= {CHANNELS{dftStages(2'b00)}};
      end else begin
         for (int c = 0; c < CHANNELS; c++) begin
            stageEnable[c] <= dftStages(chanCtrl[c].decCode);
         end
      end
   end
endmodule : dft_frequency_translation
`default_nettype wire

/* File: tb/dft_ft_chk.sv */
// assertion checker for the frequency translation front end
`include "dft_params.svh"
`default_nettype none
module dft_ft_chk #(
   parameter int         CHANNELS   = 4,
   parameter int         FIFO_DEPTH = 16,
   parameter logic [7:0] DEC_MAP    = 8'hE4
) (
   input wire logic                                  mclk,
   input wire logic                                  rst_b,
   input wire logic                                  adcValid,
   input wire logic                                  adcReady,
   input wire logic                                  regWrEn,
   input wire logic [`DFT_ADDR_W-1:0]                regAddr,
   input wire logic [7:0]                            regWrData,
   input wire logic [7:0]                            regRdData,
   input wire logic                                  chanValid,
   input wire logic                                  chanReady,
   input wire dft_pkg::dft_sample_t [CHANNELS-1:0]   chanData,
   input wire dft_pkg::dft_stage_en_t [CHANNELS-1:0] stageEnable
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   int occ;
   sequence s_take;
      adcValid && adcReady;
   endsequence
   sequence s_wr_ch0;
      regWrEn && regAddr == `DFT_ADDR_CH0;
   endsequence
   function automatic logic [3:0] stg(logic [7:0] d);
      return 4'((5'h02 << DEC_MAP[2 * d[1:0] +: 2]) - 5'h01);
   endfunction : stg
   // words held between the input and output handshakes
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         occ <= 0;
      end else begin
         occ <= occ + int'(adcValid && adcReady) - int'(chanValid && chanReady);
      end
   end
   a_first_stage: assert property (&{stageEnable[0][0], stageEnable[1][0], stageEnable[2][0], stageEnable[3][0]})
      else $error("stage one not enabled");
   a_stage_chain: assert property (stageEnable[0][3] |-> stageEnable[0][2] && stageEnable[0][1])
      else $error("stage four without stages two and three");
   a_dec_map: assert property (s_wr_ch0 |-> ##2 stageEnable[0] == stg($past(regWrData, 2)))
      else $error("stage enables do not follow decimation code");
   a_unmapped_zero: assert property (!(regAddr inside {`DFT_ADDR_SYNC, `DFT_ADDR_CH0, `DFT_ADDR_CH1,
      `DFT_ADDR_CH2, `DFT_ADDR_CH3}) |=> regRdData == 8'h00) else $error("unmapped read not zero");
   a_reg_readback: assert property (regWrEn && regAddr == `DFT_ADDR_CH1 ##1 !regWrEn &&
      regAddr == `DFT_ADDR_CH1 |=> regRdData == $past(regWrData, 2)) else $error("readback mismatch");
   a_ready_gap: assert property (s_take |=> !adcReady)
      else $error("ready high right after accept");
   a_out_hold: assert property (chanValid && !chanReady |=> chanValid && $stable(chanData))
      else $error("output changed while stalled");
   a_out_latency: assert property (s_take and (!chanValid && chanReady) |-> ##[1:4] chanValid)
      else $error("no output after accept");
   a_fifo_bound: assert property (occ <= FIFO_DEPTH + 3)
      else $error("more words accepted than buffered");
endmodule : dft_ft_chk
bind dft_frequency_translation dft_ft_chk #(
   .CHANNELS(CHANNELS), .FIFO_DEPTH(FIFO_DEPTH), .DEC_MAP(DEC_MAP)
) u_chk (
   .mclk(mclk), .rst_b(rst_b), .adcValid(adcValid), .adcReady(adcReady), .regWrEn(regWrEn),
   .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .chanValid(chanValid),
   .chanReady(chanReady), .chanData(chanData), .stageEnable(stageEnable)
);
`default_nettype wire

/* File: tb/dft_stream_partner.sv */
// sample source and downstream sink around the front end
`default_nettype none
module dft_stream_partner (
   input  wire logic                       mclk,
   input  wire logic                       rst_b,
   output logic                            adcValid,
   input  wire logic                       adcReady,
   output dft_pkg::dft_sample_t            adcSample,
   input  wire logic                       chanValid,
   output logic                            chanReady,
   input  wire dft_pkg::dft_sample_t [3:0] chanData,
   input  wire logic [1:0]                 stall
);
   timeunit 1ns;
   timeprecision 1ps;
   dft_pkg::dft_sample_t       srcQ[$];
   dft_pkg::dft_sample_t [3:0] gotQ[$];
   initial begin
      adcValid = 1'b0;
      adcSample = '0;
      chanReady = 1'b0;
   end
   always @(posedge mclk) begin
      if (adcValid && adcReady) begin
         void'(srcQ.pop_front());
      end
      if (chanValid && chanReady) begin
         gotQ.push_back(chanData);
      end
   end
   // idle data toggles so a stale word never looks fresh
   always @(negedge mclk) begin
      if (srcQ.size() > 0 && rst_b) begin
         adcValid <= 1'b1;
         adcSample <= srcQ[0];
      end else begin
         adcValid <= 1'b0;
         adcSample <= ~adcSample;
      end
      chanReady <= (stall == 2'h0) || (stall == 2'h1 && $urandom % 2 == 0);
   end
endmodule : dft_stream_partner
`default_nettype wire

/* File: tb/dft_frequency_translation_tb.sv */
// self-checking bench for the frequency translation front end
`include "dft_params.svh"
`default_nettype none
module dft_frequency_translation_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0]  DEC_MAP = 8'hE4;
   localparam logic [11:0] REGS[5] = '{`DFT_ADDR_SYNC, `DFT_ADDR_CH0, `DFT_ADDR_CH1, `DFT_ADDR_CH2, `DFT_ADDR_CH3};
   logic                         mclk = 1'b0;
   logic                         rst_b = 1'b0;
   logic                         adcValid;
   logic                         adcReady;
   dft_pkg::dft_sample_t         adcSample;
   logic [3:0][11:0]             tune = '0;
   logic [3:0][11:0]             phase = '0;
   logic                         syncPin = 1'b0;
   logic                         syncPinEnable = 1'b0;
   logic                         regWrEn = 1'b0;
   logic [11:0]                  regAddr = '0;
   logic [7:0]                   regWrData = '0;
   logic [7:0]                   regRdData;
   logic                         chanValid;
   logic                         chanReady;
   dft_pkg::dft_sample_t [3:0]   chanData;
   dft_pkg::dft_stage_en_t [3:0] stageEnable;
   logic [1:0]                   stall = 2'h0;
   logic [7:0]                   v;
   int                           errors = 0;
   int                           comparisons = 0;
   int                           md[4];
   int                           cx[4];
   always #4 mclk = ~mclk;
   dft_frequency_translation #(.DEC_MAP(DEC_MAP)) u_dut (.mclk(mclk), .rst_b(rst_b), .adcValid(adcValid),
      .adcReady(adcReady), .adcSample(adcSample), .tuneWord(tune), .phaseWord(phase), .syncPin(syncPin),
      .syncPinEnable(syncPinEnable), .regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData),
      .regRdData(regRdData), .chanValid(chanValid), .chanReady(chanReady), .chanData(chanData),
      .stageEnable(stageEnable));
   dft_stream_partner u_par (.mclk(mclk), .rst_b(rst_b), .adcValid(adcValid), .adcReady(adcReady),
      .adcSample(adcSample), .chanValid(chanValid), .chanReady(chanReady), .chanData(chanData), .stall(stall));
   task automatic finish_test();
      if (errors == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : finish_test
   task automatic chk8(string nm, logic [7:0] ex, logic [7:0] got);
      comparisons++;
      if (got !== ex) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk8
   task automatic cmp(string nm, int ex, logic signed [15:0] got);
      comparisons++;
      if (^got === 1'bx || ex - int'(got) > 4 || int'(got) - ex > 4) begin
         errors++;
         $display("[ERR] %s expected %0d seen %0d", nm, ex, got);
      end
   endtask : cmp
   function automatic int cosq(int p);
      return ((p & 3) == 0) ? 1 : ((p & 3) == 2) ? -1 : 0;
   endfunction : cosq
   function automatic logic [11:0] ftw_of(real fc, real fs);
      return 12'(int'(4096.0 * (fc - fs * $rtoi(fc / fs)) / fs));
   endfunction : ftw_of
   task automatic wr(logic [11:0] a, logic [7:0] d);
      @(negedge mclk);
      regWrEn = 1'b1;
      regAddr = a;
      regWrData = d;
      @(negedge mclk);
      regWrEn = 1'b0;
   endtask : wr
   task automatic rd_chk(logic [11:0] a, logic [7:0] ex);
      @(negedge mclk);
      regAddr = a;
      @(negedge mclk);
      chk8("regRdData", ex, regRdData);
   endtask : rd_chk
   task automatic setup(int m[4], int c[4], logic [11:0] f[4], logic [11:0] p[4]);
      for (int ch = 0; ch < 4; ch++) begin
         md[ch] = m[ch];
         cx[ch] = c[ch];
         wr(12'h310 + 12'(ch * 32), 8'(c[ch] * 128 + m[ch] * 16));
      end
      tune = {f[3], f[2], f[1], f[0]};
      @(negedge mclk);
      phase = {p[3], p[2], p[1], p[0]};
   endtask : setup
   task automatic pulse(logic en);
      @(negedge mclk);
      syncPinEnable = en;
      syncPin = 1'b1;
      repeat (4) @(negedge mclk);
      syncPin = 1'b0;
      repeat (6) @(negedge mclk);
   endtask : pulse
   // expected output per channel from mode, phase quarter and mixer scaling
   task automatic chk_beat(int k, int n, dft_pkg::dft_sample_t x);
      dft_pkg::dft_sample_t [3:0] y;
      int xi, xq, p, c, s, a, ei, eq;
      y = u_par.gotQ[k];
      for (int ch = 0; ch < 4; ch++) begin
         xi = (md[ch] == 3) ? 32734 : int'(x.i);
         xq = (cx[ch] == 0) ? 0 : (md[ch] == 3) ? 32734 : int'(x.q);
         p = (md[ch] == 2) ? n : (int'(phase[ch]) + n * int'(tune[ch])) >>> 10;
         c = cosq(p);
         s = cosq(p + 3);
         a = (md[ch] == 2) ? 32768 : 32580;
         ei = (xi * c * a) >>> 16;
         eq = (-xi * s * a) >>> 16;
         if (md[ch] == 1) begin
            ei = xi;
            eq = xq;
         end else if (cx[ch] != 0) begin
            ei = int'((longint'(xi * c + xq * s) * a * 23039) >>> 30);
            eq = int'((longint'(xq * c - xi * s) * a * 23039) >>> 30);
         end
         cmp("chanData.i", ei, y[ch].i);
         cmp("chanData.q", eq, y[ch].q);
      end
   endtask : chk_beat
   task automatic batch(int cnt, int n0, logic [1:0] st);
      dft_pkg::dft_sample_t xs[$];
      int last;
      int same;
      int t;
      u_par.gotQ.delete();
      for (int k = 0; k < cnt; k++) begin
         xs.push_back(32'($urandom));
      end
      @(negedge mclk);
      stall = st;
      foreach (xs[k]) begin
         u_par.srcQ.push_back(xs[k]);
      end
      same = 0;
      last = cnt;
      for (t = 0; t < 300 && st == 2'h2 && same < 12; t++) begin
         @(negedge mclk);
         same = (u_par.srcQ.size() == last) ? same + 1 : 0;
         last = u_par.srcQ.size();
      end
      if (st == 2'h2) begin
         comparisons++;
         if (t >= 300 || cnt - last < 16 || cnt - last > 19) begin
            errors++;
            $display("[ERR] fifo fill expected 16 to 19 seen %0d", cnt - last);
         end
         stall = 2'h1;
      end
      for (t = 0; t < 2000 && u_par.gotQ.size() < cnt; t++) begin
         @(negedge mclk);
      end
      if (u_par.gotQ.size() < cnt) begin
         errors++;
         $display("[ERR] output count expected %0d seen %0d", cnt, u_par.gotQ.size());
         finish_test();
      end
      foreach (xs[k]) begin
         chk_beat(k, n0 + k, xs[k]);
      end
   endtask : batch
   initial begin
      void'($urandom(32'hD2EF));
      repeat (6) @(negedge mclk);
      rst_b = 1'b1;
      foreach (REGS[r]) begin
         rd_chk(REGS[r], 8'h00);
      end
      wr(12'h320, 8'hFF);
      rd_chk(12'h320, 8'h00);
      wr(`DFT_ADDR_SYNC, 8'h13);
      rd_chk(`DFT_ADDR_SYNC, 8'h13);
      for (int k = 0; k < 16; k++) begin
         v = 8'((k / 4 % 2) * 128 + (k / 4 + k % 4) % 4);
         wr(12'h310 + 12'(k % 4 * 32), v);
         rd_chk(12'h310 + 12'(k % 4 * 32), v);
         chk8("stageEnable", 8'(4'((5'h02 << DEC_MAP[2 * v[1:0] +: 2]) - 5'h01)), 8'(stageEnable[k % 4]));
      end
      setup('{0, 0, 1, 3}, '{0, 1, 1, 0}, '{ftw_of(125.0, 500.0), 12'h000, 12'h5A5, ftw_of(-125.0, 500.0)},
            '{12'h000, 12'h400, 12'h000, 12'h000});
      wr(`DFT_ADDR_SYNC, 8'h10);
      wr(`DFT_ADDR_SYNC, 8'h00);
      batch(24, 0, 2'h2);
      setup('{2, 1, 0, 0}, '{0, 0, 0, 1}, '{12'h000, 12'h000, ftw_of(250.0, 500.0), ftw_of(625.0, 500.0)},
            '{12'h000, 12'h000, 12'h400, 12'hC00});
      wr(`DFT_ADDR_SYNC, 8'h01);
      pulse(1'b1);
      batch(13, 0, 2'h1);
      // pin disabled: accumulators must carry on from sample 13
      pulse(1'b0);
      batch(9, 13, 2'h0);
      finish_test();
   end
endmodule : dft_frequency_translation_tb
`default_nettype wire
